/* File: dcf_fifo_channel.sv */
// One flagged FIFO channel: storage, four occupancy flags, offset registers.
// Assumes write_clock and read_clock run at most a quarter of core_clk;
// every pin is brought in through two flip-flops and edges are detected here.
`timescale 1ns/1ps

module dcf_fifo_channel #(
  parameter int unsigned DEPTH = dcf_pkg::DEF_DEPTH,
  parameter int unsigned WIDTH = dcf_pkg::DEF_WIDTH
) (
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic             clk_en,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [3:0]       wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  input  wire logic             write_clock,
  input  wire logic             read_clock,
  input  wire logic [WIDTH-1:0] data_in,
  input  wire logic             write_enable_primary_n,
  input  wire logic             write_enable_secondary_or_load,
  input  wire logic             read_enable_primary_n,
  input  wire logic             read_enable_secondary_n,
  input  wire logic             output_drive_enable_n,
  output logic      [WIDTH-1:0] data_out,
  output logic                  data_out_en,
  output logic                  full_flag_n,
  output logic                  almost_full_flag_n,
  output logic                  almost_empty_flag_n,
  output logic                  empty_flag_n
);
  import dcf_pkg::*;

  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned CW = AW + 1;
  localparam int unsigned PW = $bits(dcf_pins_t) + WIDTH;

  // ==========================================================
  // Elaboration checks
  if (DEPTH < 16 || DEPTH > 32768 || (1 << AW) != DEPTH) begin : gBadDepth
    $error("DEPTH must be a power of two from 16 to 32768");
  end
  if (WIDTH < 8 || WIDTH > 16) begin : gBadWidth
    $error("WIDTH must lie between 8 and 16");
  end

  // ==========================================================
  // Pin synchronisers
  dcf_pins_t pinRaw;
  logic [PW-1:0] syncA;
  logic [PW-1:0] syncB;
  dcf_pins_t pinS;
  logic [WIDTH-1:0] dataS;
  logic prevWrClk;
  logic prevRdClk;

  assign pinRaw = '{wrClk: write_clock, rdClk: read_clock,
                    wrEnPrimN: write_enable_primary_n,
                    wrEnSecLd: write_enable_secondary_or_load,
                    rdEnPrimN: read_enable_primary_n,
                    rdEnSecN: read_enable_secondary_n,
                    outDriveN: output_drive_enable_n};

  // Data travels with its clock so both arrive in the same cycle
  always_ff @(posedge core_clk) begin
    if (clk_en) begin
      syncA <= {pinRaw, data_in};
      syncB <= syncA;
    end
  end

  assign pinS  = syncB[PW-1:WIDTH];
  assign dataS = syncB[WIDTH-1:0];

  // Pin clocks run free through reset; edge history keeps following them,
  // so a clock that is high at release does not look like a fresh rise
  always_ff @(posedge core_clk) begin
    if (reset) begin
      prevWrClk <= pinS.wrClk;
      prevRdClk <= pinS.rdClk;
    end else if (clk_en) begin
      prevWrClk <= pinS.wrClk;
      prevRdClk <= pinS.rdClk;
    end
  end

  wire wrEdge = clk_en & pinS.wrClk & ~prevWrClk;
  wire rdEdge = clk_en & pinS.rdClk & ~prevRdClk;

  // ==========================================================
  // Mode strap and offset registers
  logic       loadMode;
  logic [7:0] ofsReg [OFS_REGS];
  logic [1:0] wrSel;
  logic [1:0] rdSel;
  logic       flush;

  // Strap follows the pin while reset is held, then freezes
  always_ff @(posedge core_clk) begin
    if (reset && clk_en) begin
      loadMode <= ~pinS.wrEnSecLd;
    end
  end

  // Offset access only while the load pin is held low in load mode
  wire ldActive = loadMode & ~pinS.wrEnSecLd;
  wire ofsWrite = wrEdge & ldActive & ~pinS.wrEnPrimN;
  wire bothRdN  = ~pinS.rdEnPrimN & ~pinS.rdEnSecN;
  wire ofsRead  = rdEdge & ldActive & bothRdN;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      ofsReg[SEL_EMPTY_LO] <= OFS_DEFAULT[7:0];
      ofsReg[SEL_EMPTY_HI] <= OFS_DEFAULT[15:8];
      ofsReg[SEL_FULL_LO]  <= OFS_DEFAULT[7:0];
      ofsReg[SEL_FULL_HI]  <= OFS_DEFAULT[15:8];
      wrSel                <= SEL_EMPTY_LO;
      rdSel                <= SEL_EMPTY_LO;
    end else begin
      if (ofsWrite) begin
        ofsReg[wrSel] <= dataS[7:0];
        wrSel         <= wrSel + 2'h1;
      end
      if (ofsRead) begin
        rdSel <= rdSel + 2'h1;
      end
    end
  end

  // Offsets beyond the depth are not meaningful
  logic [15:0] nOfs;
  logic [15:0] mOfs;
  assign nOfs = loadMode ? {ofsReg[SEL_EMPTY_HI], ofsReg[SEL_EMPTY_LO]}
                         : OFS_DEFAULT;
  assign mOfs = loadMode ? {ofsReg[SEL_FULL_HI], ofsReg[SEL_FULL_LO]}
                         : OFS_DEFAULT;

  // ==========================================================
  // Storage and pointers
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [CW-1:0]    count;
  logic [CW-1:0]    next_count;
  dcf_flags_t       flags;

  wire wrPrimary = ~pinS.wrEnPrimN;
  // A high secondary pin lets a write through in both strap modes
  wire wrSecond  = pinS.wrEnSecLd;
  wire wrDo      = wrEdge & wrPrimary & wrSecond & flags.fullN;
  wire rdDo      = rdEdge & ~ldActive & bothRdN & flags.emptyN;

  always_comb begin
    next_count = count;
    if (wrDo && !rdDo) begin
      next_count = count + 1'b1;
    end else if (rdDo && !wrDo) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (wrDo) begin
      mem[wrPtr] <= dataS;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset || flush) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (wrDo) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (rdDo) begin
        rdPtr <= rdPtr + 1'b1;
      end
      count <= next_count;
    end
  end

  // ==========================================================
  // Flags
  logic [15:0] cnt16;
  logic [16:0] afLimit;
  assign cnt16   = 16'(count);
  assign afLimit = 17'(DEPTH) - {1'b0, mOfs};

  // Full flag looks at the count after this edge so no overflow slips in;
  // a read only releases full at the next write edge, the price of one domain
  always_ff @(posedge core_clk) begin
    if (reset || flush) begin
      flags.fullN       <= FLAGS_RESET.fullN;
      flags.almostFullN <= FLAGS_RESET.almostFullN;
    end else if (wrEdge) begin
      flags.fullN       <= (next_count != CW'(DEPTH));
      flags.almostFullN <= ({1'b0, cnt16} < afLimit);
    end
  end

  // Almost flags use the count before the edge's own access
  always_ff @(posedge core_clk) begin
    if (reset || flush) begin
      flags.emptyN       <= FLAGS_RESET.emptyN;
      flags.almostEmptyN <= FLAGS_RESET.almostEmptyN;
    end else if (rdEdge) begin
      flags.emptyN       <= (next_count != '0);
      flags.almostEmptyN <= (cnt16 > nOfs);
    end
  end

  assign full_flag_n         = flags.fullN;
  assign almost_full_flag_n  = flags.almostFullN;
  assign almost_empty_flag_n = flags.almostEmptyN;
  assign empty_flag_n        = flags.emptyN;

  // ==========================================================
  // Output register
  always_ff @(posedge core_clk) begin
    if (reset || flush) begin
      data_out    <= '0;
    end else if (rdDo) begin
      data_out    <= mem[rdPtr];
    end else if (ofsRead) begin
      data_out    <= WIDTH'(ofsReg[rdSel]);
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      data_out_en <= 1'b0;
    end else if (clk_en) begin
      data_out_en <= ~pinS.outDriveN;
    end
  end

  // ==========================================================
  // Wishbone slave
  // Registered ack: one wait state, and a raised ack blocks a second take
  logic [31:0] statusWord;
  logic [31:0] readWord;
  wire         wbReq    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire         hitStat  = (wb_adr_i == ADR_STATUS);
  wire         hitCtrl  = (wb_adr_i == ADR_CTRL);
  wire         flushReq = wbReq & wb_we_i & hitCtrl & wb_sel_i[0]
                          & wb_dat_i[CTRL_FLUSH];

  always_comb begin
    statusWord = '0;
    statusWord[STAT_CNT_LSB +: 16] = cnt16;
    statusWord[STAT_FLG_LSB +: 4]  = flags;
    statusWord[STAT_MODE]          = loadMode;
    statusWord[STAT_WSEL +: 2]     = wrSel;
    statusWord[STAT_RSEL +: 2]     = rdSel;
  end

  // Unmapped addresses and the write-only control word read as zero
  assign readWord = hitStat ? statusWord : 32'h0000_0000;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
      flush    <= 1'b0;
    end else if (clk_en) begin
      wb_ack_o <= wbReq;
      flush    <= flushReq;
      if (wbReq && !wb_we_i) begin
        wb_dat_o <= readWord;
      end
    end
  end

endmodule

/* File: dcf_pkg.sv */
// Shared constants and carrier types for the flagged FIFO channel.
// Assumes a single core clock; pin-side clocks are sampled, not used as clocks.
package dcf_pkg;

  // ==========================================================
  // Geometry defaults
  localparam int unsigned DEF_DEPTH = 4096;
  localparam int unsigned DEF_WIDTH = 9;
  localparam int unsigned OFS_REGS  = 4;

  // ==========================================================
  // Offset registers: default offset of seven words
  localparam logic [15:0] OFS_DEFAULT = 16'h0007;
  localparam logic [1:0]  SEL_EMPTY_LO = 2'h0;
  localparam logic [1:0]  SEL_EMPTY_HI = 2'h1;
  localparam logic [1:0]  SEL_FULL_LO  = 2'h2;
  localparam logic [1:0]  SEL_FULL_HI  = 2'h3;

  // ==========================================================
  // Wishbone register map (byte addresses)
  localparam logic [3:0] ADR_STATUS    = 4'h0;
  localparam logic [3:0] ADR_CTRL      = 4'h4;
  localparam int unsigned CTRL_FLUSH   = 0;
  localparam int unsigned STAT_CNT_LSB = 0;
  localparam int unsigned STAT_FLG_LSB = 16;
  localparam int unsigned STAT_MODE    = 24;
  localparam int unsigned STAT_WSEL    = 25;
  localparam int unsigned STAT_RSEL    = 27;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic fullN;
    logic almostFullN;
    logic almostEmptyN;
    logic emptyN;
  } dcf_flags_t;

  localparam dcf_flags_t FLAGS_RESET = '{fullN: 1'b1, almostFullN: 1'b1,
                                         almostEmptyN: 1'b0, emptyN: 1'b0};

  typedef struct packed {
    logic wrClk;
    logic rdClk;
    logic wrEnPrimN;
    logic wrEnSecLd;
    logic rdEnPrimN;
    logic rdEnSecN;
    logic outDriveN;
  } dcf_pins_t;

endpackage

/* File: dcf_fifo_channel_asserts.sv */
// Port checker for one FIFO channel.
// Assumes clk_en high and pin clocks sampled on core_clk.
`timescale 1ns/1ps
module dcf_chk #(
  parameter int unsigned WIDTH = 9
) (
  input wire logic             core_clk,
  input wire logic             reset,
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic             wb_ack_o,
  input wire logic             write_clock,
  input wire logic             read_clock,
  input wire logic             output_drive_enable_n,
  input wire logic [WIDTH-1:0] data_out,
  input wire logic             data_out_en,
  input wire logic             full_flag_n,
  input wire logic             almost_full_flag_n,
  input wire logic             almost_empty_flag_n,
  input wire logic             empty_flag_n
);
  // ====
  // Recent pin clock rises; a flush ack also moves outputs
  logic [4:0] wHist;
  logic [4:0] rHist;
  logic       ackD;
  wire        wNear = |(wHist[3:0] & ~wHist[4:1]);
  wire        rNear = |(rHist[3:0] & ~rHist[4:1]);
  wire        ackNear = wb_ack_o | ackD;
  always_ff @(posedge core_clk) begin
    wHist <= {wHist[3:0], write_clock};
    rHist <= {rHist[3:0], read_clock};
    ackD <= wb_ack_o;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // ====
  // Properties
  property p_rst; $fell(reset) |-> !data_out_en && data_out == '0 &&
    {full_flag_n, almost_full_flag_n, almost_empty_flag_n, empty_flag_n} == 4'hc; endproperty
  a_rst: assert property (p_rst) else $error("bad state after reset");
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("bus ack late");
  property p_ack1; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack1: assert property (p_ack1) else $error("bus ack too long");
  property p_fw; $changed({full_flag_n, almost_full_flag_n}) |-> wNear || ackNear; endproperty
  a_fw: assert property (p_fw) else $error("full side moved off write edge");
  property p_er; $changed({empty_flag_n, almost_empty_flag_n}) |-> rNear || ackNear; endproperty
  a_er: assert property (p_er) else $error("empty side moved off read edge");
  property p_do; $changed(data_out) |-> rNear || ackNear; endproperty
  a_do: assert property (p_do) else $error("output word moved off read edge");
  property p_fi; !full_flag_n |-> !almost_full_flag_n; endproperty
  a_fi: assert property (p_fi) else $error("full without almost full");
  property p_oe; data_out_en == !$past(output_drive_enable_n, 3); endproperty
  a_oe: assert property (p_oe) else $error("output enable latency");
endmodule

bind dcf_fifo_channel dcf_chk #(.WIDTH(WIDTH)) dcf_chk_i (
  .core_clk              (core_clk),
  .reset                 (reset),
  .wb_cyc_i              (wb_cyc_i),
  .wb_stb_i              (wb_stb_i),
  .wb_ack_o              (wb_ack_o),
  .write_clock           (write_clock),
  .read_clock            (read_clock),
  .output_drive_enable_n (output_drive_enable_n),
  .data_out              (data_out),
  .data_out_en           (data_out_en),
  .full_flag_n           (full_flag_n),
  .almost_full_flag_n    (almost_full_flag_n),
  .almost_empty_flag_n   (almost_empty_flag_n),
  .empty_flag_n          (empty_flag_n)
);

/* File: dcf_pin_agent.sv */
// Writer and reader logic facing the channel pins.
// Assumes each task is entered just after a core_clk rise.
// One pin bundle carries every input control, so channels could share it.
`timescale 1ns/1ps
module dcf_pin_agent (
  input  wire logic          core_clk,
  output dcf_pkg::dcf_pins_t pins,
  output logic [8:0]         dataIn,
  output logic               opDone
);
  import dcf_pkg::*;
  initial begin
    pins = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
    dataIn = '0;
    opDone = 1'b0;
  end
  // ====
  // One pin clock period, high two core cycles and low three
  task automatic cyc(input logic w);
    if (w) pins.wrClk <= 1'b1;
    else pins.rdClk <= 1'b1;
    repeat (2) @(posedge core_clk);
    pins.wrClk <= 1'b0;
    pins.rdClk <= 1'b0;
    dataIn <= ~dataIn;  // Data is held only while the pin clock is high, then changes with its fall
    repeat (2) @(posedge core_clk);
    opDone <= 1'b1;
    @(posedge core_clk);
    opDone <= 1'b0;
  endtask
  task automatic wr(input logic [8:0] d, input logic primN, input logic sec, input logic oeN);
    pins.wrEnPrimN <= primN;
    pins.wrEnSecLd <= sec;
    pins.outDriveN <= oeN;
    dataIn <= d;
    cyc(1'b1);
  endtask
  task automatic rd(input logic ld, input logic oeN);
    pins.wrEnPrimN <= 1'b1;
    pins.wrEnSecLd <= ld;
    pins.rdEnPrimN <= 1'b0;
    pins.rdEnSecN <= 1'b0;
    pins.outDriveN <= oeN;
    cyc(1'b0);
  endtask
  // Clocks keep running while the strap is held through reset
  task automatic spin(input logic strap);
    pins.wrEnPrimN <= 1'b1;
    pins.wrEnSecLd <= strap;
    pins.rdEnPrimN <= 1'b1;
    pins.outDriveN <= 1'b1;
    // Explicit levels, so the clocks never inherit an unset start value
    for (int k = 0; k < 8; k++) begin
      pins.wrClk <= ~k[0];
      pins.rdClk <= ~k[0];
      repeat (2) @(posedge core_clk);
    end
  endtask
endmodule

/* File: tb_top.sv */
// Queue-checked bench for one FIFO channel.
// Assumes bus and pin traffic never overlap.
`timescale 1ns/1ps
module tb_top;
  import dcf_pkg::*;
  localparam int D = 16;
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic        clkEn = 1'b1;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic [3:0]  adr = '0;
  logic [31:0] wdat = '0;
  wire  [31:0] rdat;
  wire         ack;
  wire  [8:0]  dout;
  wire  [3:0]  flg;
  wire  [8:0]  din;
  wire         done;
  wire         den;
  dcf_pins_t   pins;
  logic [31:0] expQ [$];
  logic [8:0]  mem [$];
  logic [7:0]  ofs [4];
  logic [8:0]  last;
  logic        fN, afN, aeN, eN, mode;
  logic [1:0]  wp, rp;
  int          cnt, n, m, failCount, checks;
  dcf_fifo_channel #(.DEPTH(D)) dcf_fifo_channel_i (
    .core_clk(core_clk), .reset(reset), .clk_en(clkEn), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .write_clock(pins.wrClk), .read_clock(pins.rdClk), .data_in(din),
    .write_enable_primary_n(pins.wrEnPrimN), .write_enable_secondary_or_load(pins.wrEnSecLd),
    .read_enable_primary_n(pins.rdEnPrimN), .read_enable_secondary_n(pins.rdEnSecN),
    .output_drive_enable_n(pins.outDriveN), .data_out(dout), .data_out_en(den),
    .full_flag_n(flg[3]), .almost_full_flag_n(flg[2]), .almost_empty_flag_n(flg[1]),
    .empty_flag_n(flg[0]));
  dcf_pin_agent dcf_pin_agent_i (.core_clk(core_clk), .pins(pins), .dataIn(din), .opDone(done));
  initial forever #25 core_clk = ~core_clk;
  // ====
  // Checking
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failCount++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tallyAndFinish;
    if (failCount == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge core_clk) if ((ack && !we) || done)
    chk(done ? {18'h0, den, dout, flg} : rdat, expQ.pop_front());
  // ====
  // Drivers with their expectations
  task automatic wrOp(input logic primN, input logic sec, input logic [8:0] d);
    int b;
    logic oeN;
    b = cnt;
    oeN = 1'($urandom);
    m = mode ? {ofs[3], ofs[2]} : 7;
    if (mode && !sec && !primN) begin
      ofs[wp] = d[7:0];
      wp++;
    end else if (!primN && sec && fN) begin
      mem.push_back(d);
      cnt++;
    end
    fN = cnt != D;
    afN = b < D - m;
    expQ.push_back({18'h0, ~oeN, last, fN, afN, aeN, eN});
    dcf_pin_agent_i.wr(d, primN, sec, oeN);
  endtask
  task automatic rdOp(input logic ld);
    int b;
    logic oeN;
    b = cnt;
    oeN = 1'($urandom);
    n = mode ? {ofs[1], ofs[0]} : 7;
    if (mode && !ld) begin
      last = {1'b0, ofs[rp]};
      rp++;
    end else if (eN) begin
      last = mem.pop_front();
      cnt--;
    end
    eN = cnt != 0;
    aeN = b > n;
    expQ.push_back({18'h0, ~oeN, last, fN, afN, aeN, eN});
    dcf_pin_agent_i.rd(ld, oeN);
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int i;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    i = 0;
    do begin
      @(posedge core_clk);
      i++;
    end while (!ack && i < 20);
    cyc <= 1'b0;
    if (!ack) begin
      failCount++;
      tallyAndFinish();
    end
    @(posedge core_clk);
  endtask
  task automatic clr;
    cnt = 0;
    {fN, afN, aeN, eN} = 4'hc;
    last = '0;
    mem.delete();
  endtask
  task automatic status;
    expQ.push_back({3'h0, rp, wp, mode, 4'h0, fN, afN, aeN, eN, 16'(cnt)});
    wb(1'b0, ADR_STATUS, '0);
  endtask
  task automatic doReset(input logic strap);
    reset <= 1'b1;
    dcf_pin_agent_i.spin(strap);
    reset <= 1'b0;
    repeat (3) @(posedge core_clk);
    clr();
    mode = !strap;
    wp = '0;
    rp = '0;
    ofs = '{8'h07, 8'h00, 8'h07, 8'h00};
  endtask
  // Clock enable low: a whole write pulse passes unseen and nothing moves
  task automatic frozenWr;
    logic oeN;
    oeN = pins.outDriveN;
    clkEn <= 1'b0;
    expQ.push_back({18'h0, ~oeN, last, fN, afN, aeN, eN});
    dcf_pin_agent_i.wr(9'h0ff, 1'b0, 1'b1, oeN);
    clkEn <= 1'b1;
  endtask
  // Fill past full, drain past empty, then flush over the bus
  task automatic fillDrain;
    int i;
    for (i = 0; i < D + 2; i++) wrOp(1'b0, 1'b1, 9'($urandom));
    for (i = 0; i < D + 3; i++) rdOp(1'b1);
    status();
    expQ.push_back('0);
    wb(1'b0, 4'h8, '0);
    expQ.push_back('0);
    wb(1'b0, ADR_CTRL, '0);
    wb(1'b1, ADR_CTRL, 32'h1);
    clr();
    status();
  endtask
  initial begin
    int i;
    void'($urandom(32'h64c5b88a));
    doReset(1'b1);
    wrOp(1'b0, 1'b0, 9'h1aa);
    frozenWr();
    fillDrain();
    doReset(1'b0);
    for (i = 0; i < 4; i++) wrOp(1'b0, 1'b0, (i == 0) ? 9'h3 : (i == 2) ? 9'h5 : 9'h0);
    for (i = 0; i < 5; i++) rdOp(1'b0);
    fillDrain();
    repeat (4) @(posedge core_clk);
    chk(32'(expQ.size()), 32'h0);
    tallyAndFinish();
  end
endmodule
